// File: hdl/sld_buf2.sv
// Purpose: two-entry valid/ready buffer for received words
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; no word is lost on a stall
`timescale 1ns/1ps
module sld_buf2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] head_next;
    logic [WIDTH-1:0] tail_reg;
    logic [WIDTH-1:0] tail_next;
    logic [1:0]       count_reg;
    logic [1:0]       count_next;
    logic             valid_reg;
    logic             valid_next;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = valid_reg;
    assign out_data  = head_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        head_next  = head_reg;
        tail_next  = tail_reg;
        count_next = count_reg;
        case ({push, pop})
            2'b10:
            begin
                if (count_reg == 2'h0)
                    head_next = in_data;
                else
                    tail_next = in_data;
                count_next = count_reg + 2'h1;
            end
            2'b01:
            begin
                head_next  = tail_reg;
                count_next = count_reg - 2'h1;
            end
            2'b11:
            begin
                if (count_reg == 2'h1)
                    head_next = in_data;
                else
                begin
                    head_next = tail_reg;
                    tail_next = in_data;
                end
            end
            default:
            begin
                head_next = head_reg;
            end
        endcase
        valid_next = (count_next != 2'h0);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            head_reg  <= '0;
            tail_reg  <= '0;
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
        end
        else
        begin
            head_reg  <= head_next;
            tail_reg  <= tail_next;
            count_reg <= count_next;
            valid_reg <= valid_next;
        end
    end
endmodule

// File: hdl/sld_pkg.sv
// Purpose: shared constants for the serial-in latched driver
// Assumes: one 25 MHz system clock
// Notes:   pin inputs are asynchronous and synchronised in the top
package sld_pkg;
    localparam int          SLD_STAGES      = 8;
    localparam int          SLD_CNT_W       = 3;
    localparam int          SLD_SYNC_DEPTH  = 2;
    localparam logic [7:0]  SLD_SHREG_RESET = 8'h00;
    localparam logic [7:0]  SLD_LATCH_RESET = 8'h00;
    localparam logic [7:0]  SLD_DRIVE_OFF   = 8'h00;
    localparam logic [2:0]  SLD_CNT_LAST    = 3'h7;
    localparam logic [2:0]  SLD_CNT_ONE     = 3'h1;
    localparam logic [2:0]  SLD_CNT_RESET   = 3'h0;
    localparam int          SLD_CLOCK_HZ    = 25000000;
endpackage

// File: hdl/sld_top.sv
// Purpose: eight-stage serial-in shift register, latches and output drivers
// Assumes: 25 MHz clock; pin inputs asynchronous, two-flop synchronised
// Notes:   completed bytes also leave through a two-entry buffer
// Operation
// - shift clock rise captures data into stage one
// - later rises move bits toward serial output
// - strobe high copies each stage into latch
// - latches stay transparent while strobe high
// - disable high turns all eight drivers off
// - disable never alters latches or shift register
// - disable low lets latches drive outputs
// - eight stages, eight latches, eight drivers
// - serial output chains into next device
`timescale 1ns/1ps
module sld_top
    import sld_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // host pins
    input  wire logic                  serial_data,
    input  wire logic                  shift_clock,
    input  wire logic                  strobe,
    input  wire logic                  output_disable,
    // driver and chain outputs
    output logic [sld_pkg::SLD_STAGES-1:0] drive_on,
    output logic                       serial_out,
    // received byte stream
    output logic                       word_valid,
    input  wire logic                  word_ready,
    output logic [sld_pkg::SLD_STAGES-1:0] word_data,
    output logic                       word_overrun
);
    import sld_pkg::*;

    logic [SLD_SYNC_DEPTH-1:0] data_sync_reg;
    logic [SLD_SYNC_DEPTH-1:0] clk_sync_reg;
    logic [SLD_SYNC_DEPTH-1:0] stb_sync_reg;
    logic [SLD_SYNC_DEPTH-1:0] dis_sync_reg;
    logic                      clk_prev_reg;
    logic                      data_s;
    logic                      clk_s;
    logic                      stb_s;
    logic                      dis_s;
    logic                      edge_seen;

    logic [SLD_STAGES-1:0]     shreg_reg;
    logic [SLD_STAGES-1:0]     shreg_next;
    logic [SLD_STAGES-1:0]     latch_reg;
    logic [SLD_STAGES-1:0]     latch_next;
    logic [SLD_STAGES-1:0]     drive_reg;
    logic [SLD_STAGES-1:0]     drive_next;
    logic                      sout_reg;
    logic                      sout_next;
    logic [SLD_CNT_W-1:0]      cnt_reg;
    logic [SLD_CNT_W-1:0]      cnt_next;
    logic                      ovr_reg;
    logic                      ovr_next;
    logic                      push;
    logic                      buf_ready;

    assign data_s    = data_sync_reg[1];
    assign clk_s     = clk_sync_reg[1];
    assign stb_s     = stb_sync_reg[1];
    assign dis_s     = dis_sync_reg[1];
    assign edge_seen = clk_s && !clk_prev_reg;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            data_sync_reg <= '0;
            clk_sync_reg  <= '0;
            stb_sync_reg  <= '0;
            dis_sync_reg  <= '0;
            clk_prev_reg  <= 1'b0;
        end
        else
        begin
            data_sync_reg <= {data_sync_reg[0], serial_data};
            clk_sync_reg  <= {clk_sync_reg[0], shift_clock};
            stb_sync_reg  <= {stb_sync_reg[0], strobe};
            dis_sync_reg  <= {dis_sync_reg[0], output_disable};
            clk_prev_reg  <= clk_s;
        end
    end

    always_comb
    begin
        shreg_next = shreg_reg;
        cnt_next   = cnt_reg;
        if (edge_seen)
        begin
            shreg_next = {shreg_reg[SLD_STAGES-2:0], data_s};
            cnt_next   = cnt_reg + SLD_CNT_ONE;
        end
        // latch follows stages only while strobe high, disable not involved
        latch_next = stb_s ? shreg_reg : latch_reg;
        drive_next = dis_s ? SLD_DRIVE_OFF : latch_reg;
        sout_next  = shreg_next[SLD_STAGES-1];
        push       = edge_seen && (cnt_reg == SLD_CNT_LAST);
        ovr_next   = ovr_reg || (push && !buf_ready);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            shreg_reg <= SLD_SHREG_RESET;
            latch_reg <= SLD_LATCH_RESET;
            drive_reg <= SLD_DRIVE_OFF;
            sout_reg  <= 1'b0;
            cnt_reg   <= SLD_CNT_RESET;
            ovr_reg   <= 1'b0;
        end
        else
        begin
            shreg_reg <= shreg_next;
            latch_reg <= latch_next;
            drive_reg <= drive_next;
            sout_reg  <= sout_next;
            cnt_reg   <= cnt_next;
            ovr_reg   <= ovr_next;
        end
    end

    assign drive_on     = drive_reg;
    assign serial_out   = sout_reg;
    assign word_overrun = ovr_reg;

    sld_buf2 #(
        .WIDTH     (SLD_STAGES)
    ) u_buf (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   ({shreg_reg[SLD_STAGES-2:0], data_s}),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    property p_capture;
        @(posedge clock) disable iff (reset)
        edge_seen |=> shreg_reg[0] == $past(data_s);
    endproperty
    a_capture: assert property (p_capture) else $error("stage one missed data");

    property p_shift;
        @(posedge clock) disable iff (reset)
        edge_seen |=> shreg_reg[7:1] == $past(shreg_reg[6:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("stages did not shift");

    property p_latch;
        @(posedge clock) disable iff (reset)
        stb_s |=> latch_reg == $past(shreg_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("latch did not load");

    property p_transparent;
        @(posedge clock) disable iff (reset)
        (stb_s && edge_seen) ##1 stb_s |=> latch_reg[0] == $past(data_s, 2);
    endproperty
    a_transparent: assert property (p_transparent) else $error("latch not transparent");

    property p_off;
        @(posedge clock) disable iff (reset)
        dis_s |=> drive_on == SLD_DRIVE_OFF;
    endproperty
    a_off: assert property (p_off) else $error("driver on while disabled");

    property p_keep;
        @(posedge clock) disable iff (reset)
        (dis_s && !stb_s && !edge_seen) |=> $stable(latch_reg) && $stable(shreg_reg);
    endproperty
    a_keep: assert property (p_keep) else $error("disable changed storage");

    property p_follow;
        @(posedge clock) disable iff (reset)
        !dis_s |=> drive_on == $past(latch_reg);
    endproperty
    a_follow: assert property (p_follow) else $error("outputs not from latches");

    property p_hold;
        @(posedge clock) disable iff (reset)
        !stb_s |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved with strobe low");

    property p_sout;
        @(posedge clock) disable iff (reset)
        serial_out == shreg_reg[SLD_STAGES-1];
    endproperty
    a_sout: assert property (p_sout) else $error("serial out not last stage");

    property p_cov_word;
        @(posedge clock) disable iff (reset)
        push ##[1:3] word_valid;
    endproperty
    c_word: cover property (p_cov_word);

    property p_cov_latch;
        @(posedge clock) disable iff (reset)
        stb_s ##1 !stb_s ##1 !dis_s && (drive_on != SLD_DRIVE_OFF);
    endproperty
    c_latch: cover property (p_cov_latch);

    property p_cov_stall;
        @(posedge clock) disable iff (reset)
        word_valid && !word_ready ##1 !buf_ready;
    endproperty
    c_stall: cover property (p_cov_stall);

    property p_cov_overrun;
        @(posedge clock) disable iff (reset)
        push && !buf_ready ##1 word_overrun;
    endproperty
    c_overrun: cover property (p_cov_overrun);
endmodule

// File: tb/sld_host.sv
// Purpose: host controller model driving the pins
// Assumes: pins change only at falling clock edges
// Notes:   shift clock stands low outside frames
`timescale 1ns/1ps
module sld_host (
    // clock
    input  wire logic clock,
    // pins
    output logic      serial_data,
    output logic      shift_clock,
    output logic      strobe,
    output logic      output_disable
);
    initial
    begin
        serial_data    = 1'b0;
        shift_clock    = 1'b0;
        strobe         = 1'b0;
        output_disable = 1'b1;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // first bit sent ends in the last stage
    task automatic send_byte(input logic [7:0] value);
        for (int i = 7; i >= 0; i--)
        begin
            serial_data = value[i];
            idle(3);
            shift_clock = 1'b1;
            idle(3);
            shift_clock = 1'b0;
            idle(1);
        end
        serial_data = 1'b0;
    endtask
    task automatic pulse_strobe();
        strobe = 1'b1;
        idle(4);
        strobe = 1'b0;
        idle(2);
    endtask
endmodule

// File: tb/sld_top_tb.sv
// Purpose: self-checking bench for the latched driver
// Assumes: host model drives all pins
// Notes:   byte stream checked through pops
`timescale 1ns/1ps
module sld_top_tb;
    import sld_pkg::*;
    typedef struct packed
    {
        logic [7:0] data;
        logic       dis;
        logic [7:0] drive;
    } sld_row_s;
    logic       clock;
    logic       reset;
    logic       serial_data;
    logic       shift_clock;
    logic       strobe;
    logic       output_disable;
    logic [7:0] drive_on;
    logic       serial_out;
    logic       word_valid;
    logic       word_ready;
    logic [7:0] word_data;
    logic       word_overrun;
    int         miscompares;
    int         comparisons;
    sld_row_s   rows [5];
    sld_host i_sld_host (
        .clock          (clock),
        .serial_data    (serial_data),
        .shift_clock    (shift_clock),
        .strobe         (strobe),
        .output_disable (output_disable)
    );
    sld_top i_sld_top (
        .clock          (clock),
        .reset          (reset),
        .serial_data    (serial_data),
        .shift_clock    (shift_clock),
        .strobe         (strobe),
        .output_disable (output_disable),
        .drive_on       (drive_on),
        .serial_out     (serial_out),
        .word_valid     (word_valid),
        .word_ready     (word_ready),
        .word_data      (word_data),
        .word_overrun   (word_overrun)
    );
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic pop(input logic [7:0] expected);
        check({7'h00, word_valid}, 8'h01);
        check(word_data, expected);
        word_ready = 1'b1;
        @(negedge clock);
        word_ready = 1'b0;
        @(negedge clock);
    endtask
    task automatic summarize();
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (6000) @(posedge clock);
        miscompares++;
        summarize();
    end
    initial
    begin
        miscompares = 0;
        comparisons = 0;
        reset       = 1'b1;
        word_ready  = 1'b0;
        rows[0] = '{8'ha5, 1'b0, 8'ha5};
        rows[1] = '{8'h3c, 1'b1, 8'h00};
        rows[2] = '{8'h81, 1'b0, 8'h81};
        rows[3] = '{8'h00, 1'b0, 8'h00};
        rows[4] = '{8'hff, 1'b1, 8'h00};
        repeat (8) @(negedge clock);
        reset = 1'b0;
        check(drive_on, SLD_DRIVE_OFF);
        for (int r = 0; r < 5; r++)
        begin
            i_sld_host.send_byte(rows[r].data);
            i_sld_host.idle(4);
            check({7'h00, serial_out}, {7'h00, rows[r].data[7]});
            pop(rows[r].data);
            i_sld_host.output_disable = rows[r].dis;
            i_sld_host.pulse_strobe();
            i_sld_host.idle(6);
            check(drive_on, rows[r].drive);
        end
        i_sld_host.output_disable = 1'b0;
        i_sld_host.idle(6);
        check(drive_on, 8'hff);
        i_sld_host.send_byte(8'h12);
        i_sld_host.idle(6);
        check(drive_on, 8'hff);
        pop(8'h12);
        i_sld_host.output_disable = 1'b1;
        i_sld_host.send_byte(8'h5a);
        i_sld_host.idle(6);
        check(drive_on, 8'h00);
        i_sld_host.output_disable = 1'b0;
        i_sld_host.idle(6);
        check(drive_on, 8'hff);
        i_sld_host.pulse_strobe();
        i_sld_host.idle(6);
        check(drive_on, 8'h5a);
        pop(8'h5a);
        i_sld_host.output_disable = 1'b1;
        i_sld_host.strobe = 1'b1;
        i_sld_host.send_byte(8'hc3);
        i_sld_host.idle(6);
        check(drive_on, 8'h00);
        i_sld_host.output_disable = 1'b0;
        i_sld_host.idle(6);
        check(drive_on, 8'hc3);
        i_sld_host.strobe = 1'b0;
        pop(8'hc3);
        i_sld_host.send_byte(8'h11);
        i_sld_host.send_byte(8'h22);
        i_sld_host.send_byte(8'h33);
        i_sld_host.idle(4);
        check({7'h00, word_overrun}, 8'h01);
        pop(8'h11);
        pop(8'h22);
        check({7'h00, word_valid}, 8'h00);
        check(drive_on, 8'hc3);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        check(drive_on, SLD_DRIVE_OFF);
        check({6'h00, word_valid, word_overrun}, 8'h00);
        check({7'h00, serial_out}, 8'h00);
        reset = 1'b0;
        i_sld_host.send_byte(8'h96);
        i_sld_host.idle(4);
        check({7'h00, serial_out}, 8'h01);
        pop(8'h96);
        summarize();
    end
endmodule
